// file: core/fspc_pkg.sv
// Constants shared by the flash self-program control block.
package fspc_pkg;

    // Control/status register: word index and byte address.
    localparam logic [7:0]  CSR_INDEX = 8'h37;
    localparam logic [11:0] CSR_ADDR  = {2'b00, CSR_INDEX, 2'b00};
    localparam logic [7:0]  CSR_RESET = 8'h00;

    // Control/status field positions.
    localparam int BIT_READY_IE    = 7;
    localparam int BIT_SECT_BUSY   = 6;
    localparam int BIT_SIG_READ    = 5;
    localparam int BIT_SECT_RD_EN  = 4;
    localparam int BIT_LOCK_READ   = 3;
    localparam int BIT_PAGE_WRITE  = 2;
    localparam int BIT_PAGE_ERASE  = 1;
    localparam int BIT_SELF_PRG_EN = 0;

    // Accepted command codes in the low five bits.
    localparam logic [4:0] CODE_SECT_RD  = 5'h11;
    localparam logic [4:0] CODE_LOCK_RD  = 5'h09;
    localparam logic [4:0] CODE_PG_WRITE = 5'h05;
    localparam logic [4:0] CODE_PG_ERASE = 5'h03;
    localparam logic [4:0] CODE_FILL     = 5'h01;

    // Arming windows in clock cycles.
    localparam logic [2:0] WIN_STORE    = 3'h4;
    localparam logic [2:0] WIN_LOAD_MIN = 3'h2;

    // Erase and write time, rounded up to whole cycles.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PROG_TIME_NS  = 3700000;
    localparam int unsigned PROG_CYCLES   =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CW = 16;

    // Sequencer states.
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_armed = 3'b010,
        st_busy  = 3'b100
    } fspc_state_e;

endpackage

// file: core/fspc_down_counter.sv
// Loadable down counter that stops at zero.
module fspc_down_counter
    import fspc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,     // System clock.
    input  wire logic         rst_n,   // Synchronous reset, active low.
    input  wire logic         load,    // Load the start value.
    input  wire logic [W-1:0] value,   // Start value.
    output logic      [W-1:0] count    // Current count.
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    always_comb
    begin
        count_d = count_q;
        if (load)
        begin
            count_d = value;
        end
        else if (count_q != '0)
        begin
            count_d = count_q - W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign count = count_q;

endmodule // fspc_down_counter

// file: core/fspc_page_buf.sv
// Temporary page buffer held in flip-flops, one entry per word.
module fspc_page_buf
    import fspc_pkg::*;
#(
    parameter int WORDS = 32,
    parameter int AW    = 5,
    parameter int DW    = 16
) (
    input  wire logic          clk,      // System clock.
    input  wire logic          rst_n,    // Synchronous reset, active low.
    input  wire logic          clear,    // Discard all entries.
    input  wire logic          wr_en,    // Store one word.
    input  wire logic [AW-1:0] wr_addr,  // Word index to store.
    input  wire logic [DW-1:0] wr_data,  // Word to store.
    input  wire logic [AW-1:0] rd_addr,  // Word index to read.
    output logic      [DW-1:0] rd_data,  // Word read, erased reads ones.
    output logic               filled    // Some entry holds data.
);

    logic [DW-1:0]    mem_q [WORDS];
    logic [WORDS-1:0] used_q;

    // Cleared entries read as erased flash so a partial page is safe.
    genvar i;
    generate
        for (i = 0; i < WORDS; i++)
        begin : g_entry
            logic          hit;
            logic [DW-1:0] mem_d;
            logic          used_d;
            assign hit = wr_en && (wr_addr == AW'(i));
            always_comb
            begin
                mem_d  = mem_q[i];
                used_d = used_q[i];
                if (clear)
                begin
                    mem_d  = '1;
                    used_d = 1'b0;
                end
                else if (hit)
                begin
                    mem_d  = wr_data;
                    used_d = 1'b1;
                end
            end
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    mem_q[i]  <= '1;
                    used_q[i] <= 1'b0;
                end
                else
                begin
                    mem_q[i]  <= mem_d;
                    used_q[i] <= used_d;
                end
            end
        end
    endgenerate

    assign rd_data = mem_q[rd_addr];
    assign filled  = |used_q;

endmodule // fspc_page_buf

// file: core/fspc_top.sv
// Flash self-program control and status with APB register access.
//
// The APB slave port is this design's own decision.

// Behaviour
// - Ready interrupt when enabled, global on, idle
// - No ready interrupt during EEPROM write, store
// - Section busy bit always reads zero
// - Signature arm makes load return signature byte
// - Store after signature arm does nothing
// - Section read enable write clears page buffer
// - Lock arm: load returns lock or fuse byte
// - Page write arm: store writes buffer to page
// - Page write bit clears on completion or timeout
// - CPU halted during whole erase or write
// - Page erase arm: store erases pointed page
// - Page erase bit clears on completion or timeout
// - Enable opens four-clock store window, self-clears
// - Plain store puts data pair into buffer
// - Enable stays set until erase/write finishes
// - Only five listed codes arm anything
// - Boot code may program any flash page
// - EEPROM write blocks commands and fuse reads
// - Buffer cleared after page write and reset
// - Programmed fuse and lock bits read zero
module fspc_top
    import fspc_pkg::*;
#(
    parameter int          PAGE_WORDS  = 32,
    parameter int          PW_BITS     = 5,
    parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
    parameter logic [31:0] SIG_ROW     = 32'h5aa53cc3  // Arbitrary value.
) (
    input  wire logic        clk,                  // System clock.
    input  wire logic        rst_n,                // Sync reset, active low.
    input  wire logic [11:0] paddr,                // APB byte address.
    input  wire logic        psel,                 // APB select.
    input  wire logic        penable,              // APB access phase.
    input  wire logic        pwrite,               // APB write.
    input  wire logic [31:0] pwdata,               // APB write data.
    input  wire logic [3:0]  pstrb,                // APB byte strobes.
    output logic      [31:0] prdata,               // APB read data.
    output logic             pready,               // APB ready.
    output logic             pslverr,              // APB error.
    input  wire logic        global_int_enable,    // CPU global interrupt.
    input  wire logic        eeprom_write_flag,    // EEPROM write running.
    input  wire logic        exec_in_boot,         // Code runs from boot.
    input  wire logic        spm_req,              // Store-program pulse.
    input  wire logic        lpm_req,              // Load-program pulse.
    input  wire logic [15:0] z_ptr,                // Pointer register.
    input  wire logic [15:0] data_register_pair,   // Word to store.
    input  wire logic [7:0]  lock_programmed,      // Lock bits programmed.
    input  wire logic [7:0]  fuse_low_programmed,  // Low fuses programmed.
    input  wire logic [7:0]  fuse_high_programmed, // High fuses programmed.
    input  wire logic [7:0]  fuse_ext_programmed,  // Ext fuses programmed.
    output logic             lpm_hit,              // Special load answered.
    output logic      [7:0]  lpm_data,             // Special load byte.
    output logic             cpu_halt,             // Stall the CPU.
    output logic             ready_irq,            // Ready interrupt.
    output logic             flash_erase,          // Page erase running.
    output logic             flash_write,          // Page write running.
    output logic [15-PW_BITS-1:0] flash_page,      // Page being programmed.
    input  wire logic [PW_BITS-1:0] flash_buf_addr, // Buffer read index.
    output logic      [15:0] flash_buf_data        // Buffer read word.
);

    localparam int PGW = 15 - PW_BITS;

    fspc_state_e      state_q;
    fspc_state_e      state_d;
    logic [5:0]       cmd_q;
    logic [5:0]       cmd_d;
    logic             ie_q;
    logic             ie_d;
    logic [PGW-1:0]   page_q;
    logic [PGW-1:0]   page_d;
    logic             erase_q;
    logic             erase_d;
    logic             write_q;
    logic             write_d;
    logic             hit_q;
    logic             hit_d;
    logic [7:0]       ldat_q;
    logic [7:0]       ldat_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             err_q;
    logic             err_d;

    logic             win_load;
    logic [2:0]       win_cnt;
    logic             prog_load;
    logic [PROG_CW-1:0] prog_cnt;
    logic             buf_clear;
    logic             buf_wr;
    logic             buf_filled;
    logic             apb_wr;
    logic [4:0]       wr_code;
    logic             code_ok;
    logic [7:0]       csr_rd;
    logic [7:0]       fuse_byte;

    assign apb_wr  = psel && penable && pwrite && pstrb[0]
                     && (paddr == CSR_ADDR);
    assign wr_code = pwdata[4:0];
    assign code_ok = (wr_code == CODE_SECT_RD) ||
                     (wr_code == CODE_LOCK_RD) ||
                     (wr_code == CODE_PG_WRITE) ||
                     (wr_code == CODE_PG_ERASE) ||
                     (wr_code == CODE_FILL);

    // Section busy is tied low: no read-while-write split.
    assign csr_rd = {ie_q, 1'b0, cmd_q[5:0]};

    // Programmed bits read back as zero.
    always_comb
    begin
        case (z_ptr[1:0])
            2'b01:   fuse_byte = ~lock_programmed;
            2'b10:   fuse_byte = ~fuse_ext_programmed;
            2'b11:   fuse_byte = ~fuse_high_programmed;
            default: fuse_byte = ~fuse_low_programmed;
        endcase
    end

    always_comb
    begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        ie_d      = ie_q;
        page_d    = page_q;
        erase_d   = erase_q;
        write_d   = write_q;
        hit_d     = 1'b0;
        ldat_d    = ldat_q;
        win_load  = 1'b0;
        prog_load = 1'b0;
        buf_clear = 1'b0;
        buf_wr    = 1'b0;
        case (state_q)
            st_armed:
            begin
                // Only boot code may store; any page is a target.
                if (spm_req && exec_in_boot)
                begin
                    if (cmd_q[BIT_PAGE_ERASE] || cmd_q[BIT_PAGE_WRITE])
                    begin
                        state_d   = st_busy;
                        prog_load = 1'b1;
                        page_d    = z_ptr[15:PW_BITS+1];
                        erase_d   = cmd_q[BIT_PAGE_ERASE];
                        write_d   = cmd_q[BIT_PAGE_WRITE];
                    end
                    else
                    begin
                        // Signature, lock and section modes ignore stores.
                        buf_wr  = (cmd_q == {1'b0, CODE_FILL});
                        cmd_d   = '0;
                        state_d = st_idle;
                    end
                end
                else if (lpm_req && (win_cnt >= WIN_LOAD_MIN)
                         && !eeprom_write_flag
                         && (cmd_q[BIT_SIG_READ]
                             || cmd_q[BIT_LOCK_READ]))
                begin
                    hit_d = 1'b1;
                    if (cmd_q[BIT_SIG_READ])
                    begin
                        ldat_d = SIG_ROW[8*z_ptr[1:0] +: 8];
                    end
                    else
                    begin
                        ldat_d = fuse_byte;
                    end
                    cmd_d   = '0;
                    state_d = st_idle;
                end
                else if (win_cnt == 3'h1)
                begin
                    cmd_d   = '0;
                    state_d = st_idle;
                end
            end
            st_busy:
            begin
                // Enable stays high so software can poll for the end.
                if (prog_cnt == PROG_CW'(1))
                begin
                    cmd_d     = '0;
                    state_d   = st_idle;
                    erase_d   = 1'b0;
                    write_d   = 1'b0;
                    buf_clear = write_q;
                end
            end
            default:
            begin
                state_d = st_idle;
            end
        endcase
        // Accepted register writes win state and command over CPU events in the same cycle, whose buffer, load and flash effects still apply.
        if (apb_wr)
        begin
            ie_d = pwdata[BIT_READY_IE];
            if ((state_q != st_busy) && !eeprom_write_flag
                && code_ok)
            begin
                cmd_d    = {pwdata[BIT_SIG_READ]
                            && (wr_code == CODE_FILL), wr_code};
                state_d  = st_armed;
                win_load = 1'b1;
                if (wr_code == CODE_SECT_RD)
                begin
                    buf_clear = 1'b1;
                end
            end
        end
        // An EEPROM write mid page load loses loaded data.
        if (eeprom_write_flag && buf_filled && (state_q != st_busy))
        begin
            buf_clear = 1'b1;
        end
    end

    // Read data latched in setup, shown in access.
    always_comb
    begin
        prdata_d = prdata_q;
        err_d    = err_q;
        if (psel && !penable)
        begin
            err_d    = (paddr != CSR_ADDR);
            prdata_d = (paddr == CSR_ADDR) ? {24'h000000, csr_rd} : '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q  <= st_idle;
            cmd_q    <= CSR_RESET[5:0];
            ie_q     <= CSR_RESET[BIT_READY_IE];
            page_q   <= '0;
            erase_q  <= 1'b0;
            write_q  <= 1'b0;
            hit_q    <= 1'b0;
            ldat_q   <= 8'h00;
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cmd_q    <= cmd_d;
            ie_q     <= ie_d;
            page_q   <= page_d;
            erase_q  <= erase_d;
            write_q  <= write_d;
            hit_q    <= hit_d;
            ldat_q   <= ldat_d;
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    fspc_down_counter #(
        .W (3)
    ) u_win (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (win_load),
        .value (WIN_STORE),
        .count (win_cnt)
    );

    fspc_down_counter #(
        .W (PROG_CW)
    ) u_prog (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (prog_load),
        .value (PROG_CW'(PROG_CYCLES_P)),
        .count (prog_cnt)
    );

    // Reset empties the buffer itself.
    fspc_page_buf #(
        .WORDS (PAGE_WORDS),
        .AW    (PW_BITS),
        .DW    (16)
    ) u_buf (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (buf_clear),
        .wr_en   (buf_wr),
        .wr_addr (z_ptr[PW_BITS:1]),
        .wr_data (data_register_pair),
        .rd_addr (flash_buf_addr),
        .rd_data (flash_buf_data),
        .filled  (buf_filled)
    );

    assign prdata      = prdata_q;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && err_q;
    assign lpm_hit     = hit_q;
    assign lpm_data    = ldat_q;
    assign cpu_halt    = (state_q == st_busy);
    assign flash_erase = erase_q;
    assign flash_write = write_q;
    assign flash_page  = page_q;
    assign ready_irq   = ie_q && global_int_enable
                         && !cmd_q[BIT_SELF_PRG_EN]
                         && !eeprom_write_flag
                         && (state_q != st_busy);

endmodule // fspc_top

// file: sim/fspc_top_assertions.sv
// Assertions on the flash self-program control ports.
module fspc_top_assertions
    import fspc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = 8,
    parameter int          PW_BITS       = 5
) (
    input wire logic                 clk,               // Clock.
    input wire logic                 rst_n,             // Reset.
    input wire logic [31:0]          prdata,            // Read data.
    input wire logic                 spm_req,           // Store.
    input wire logic                 lpm_req,           // Load.
    input wire logic [15:0]          z_ptr,             // Pointer.
    input wire logic                 eeprom_write_flag, // EEPROM busy.
    input wire logic                 lpm_hit,           // Load answered.
    input wire logic                 cpu_halt,          // Stall.
    input wire logic                 ready_irq,         // Interrupt.
    input wire logic                 flash_erase,       // Erasing.
    input wire logic                 flash_write,       // Writing.
    input wire logic [14-PW_BITS:0]  flash_page         // Page.
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0]          hcnt_q;
    logic [31:0]          hcnt_d;
    logic [14-PW_BITS:0]  z_page;

    assign z_page = z_ptr[15:PW_BITS+1];

    // Stall length, so a short or long operation is caught.
    always_comb hcnt_d = cpu_halt ? hcnt_q + 32'h1 : 32'h0;

    always_ff @(posedge clk)
        if (!rst_n)
            hcnt_q <= 32'h0;
        else
            hcnt_q <= hcnt_d;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_busy;
        cpu_halt [*8];
    endsequence
    sequence s_start;
        $rose(cpu_halt);
    endsequence

    property p_busy_zero;  !prdata[BIT_SECT_BUSY]; endproperty
    property p_irq_quiet;  eeprom_write_flag || cpu_halt |-> !ready_irq;
    endproperty
    property p_halt_len;   $fell(cpu_halt) |-> hcnt_q == PROG_CYCLES_P;
    endproperty
    property p_halt_hold;  s_start |-> s_busy; endproperty
    property p_halt_op;    cpu_halt == (flash_erase ^ flash_write);
    endproperty
    property p_halt_cause; s_start |-> $past(spm_req); endproperty
    property p_page;       s_start |-> flash_page == $past(z_page);
    endproperty
    property p_hit_cause;  lpm_hit |-> $past(lpm_req); endproperty
    property p_hit_block;  lpm_req && eeprom_write_flag |=> !lpm_hit;
    endproperty
    property p_hit_pulse;  lpm_hit |=> !lpm_hit; endproperty

    a_busy_zero: assert property (p_busy_zero)
        else $error("busy bit set");
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq while busy");
    a_halt_len: assert property (p_halt_len)
        else $error("stall length");
    a_halt_hold: assert property (p_halt_hold)
        else $error("stall short");
    a_halt_op: assert property (p_halt_op)
        else $error("stall without op");
    a_halt_cause: assert property (p_halt_cause)
        else $error("op without store");
    a_page: assert property (p_page)
        else $error("wrong page");
    a_hit_cause: assert property (p_hit_cause)
        else $error("hit without load");
    a_hit_block: assert property (p_hit_block)
        else $error("hit in eeprom write");
    a_hit_pulse: assert property (p_hit_pulse)
        else $error("hit too long");
endmodule // fspc_top_assertions

bind fspc_top fspc_top_assertions #(
    .PROG_CYCLES_P(PROG_CYCLES_P),
    .PW_BITS      (PW_BITS)
) u_fspc_top_assertions (
    .clk(clk), .rst_n(rst_n), .prdata(prdata), .spm_req(spm_req),
    .lpm_req(lpm_req), .z_ptr(z_ptr), .lpm_hit(lpm_hit),
    .eeprom_write_flag(eeprom_write_flag), .cpu_halt(cpu_halt),
    .ready_irq(ready_irq), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page)
);

// file: sim/fspc_cpu_model.sv
// CPU model issuing store and load program requests.
module fspc_cpu_model (
    input  wire logic        clk,                // System clock.
    input  wire logic        cpu_halt,           // Stall from the block.
    output logic             spm_req,            // Store pulse.
    output logic             lpm_req,            // Load pulse.
    output logic      [15:0] z_ptr,              // Pointer.
    output logic      [15:0] data_register_pair  // Word to store.
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        spm_req = 1'b0;
        lpm_req = 1'b0;
        z_ptr = 16'h0;
        data_register_pair = 16'h0;
    end

    // Call after a rising edge; s=1 store, else load.
    task automatic issue(input logic s, input logic [15:0] z, d);
        while (cpu_halt === 1'b1)
            @(posedge clk);
        spm_req <= s;
        lpm_req <= !s;
        z_ptr <= z;
        data_register_pair <= d;
        @(posedge clk);
        spm_req <= 1'b0;
        lpm_req <= 1'b0;
        // Released lines invert, so a stale sample cannot pass.
        z_ptr <= ~z;
        data_register_pair <= ~d;
    endtask
endmodule // fspc_cpu_model

// file: sim/fspc_top_tb.sv
// Testbench for the flash self-program control block.
module fspc_top_tb
    import fspc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] SIG = 32'h1e2d3c4b; // Arbitrary value.
    localparam logic [7:0]  LCK = 8'h0c;
    localparam logic [7:0]  FLO = 8'h31;
    localparam logic [7:0]  FHI = 8'h42;
    localparam logic [7:0]  FEX = 8'h05;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        gie, eep, boot, spm_req, lpm_req, lpm_hit, cpu_halt;
    logic        ready_irq, flash_erase, flash_write;
    logic [3:0]  pstrb;
    logic [4:0]  buf_addr;
    logic [7:0]  lpm_data;
    logic [9:0]  flash_page;
    logic [11:0] paddr;
    logic [15:0] z_ptr, dpair, buf_data;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, checks_done;

    fspc_top #(.PROG_CYCLES_P(8), .SIG_ROW(SIG)) u_fspc_top (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_int_enable(gie),
        .eeprom_write_flag(eep), .exec_in_boot(boot),
        .spm_req(spm_req), .lpm_req(lpm_req), .z_ptr(z_ptr),
        .data_register_pair(dpair), .lock_programmed(LCK),
        .fuse_low_programmed(FLO), .fuse_high_programmed(FHI),
        .fuse_ext_programmed(FEX), .lpm_hit(lpm_hit),
        .lpm_data(lpm_data), .cpu_halt(cpu_halt), .ready_irq(ready_irq),
        .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_page(flash_page), .flash_buf_addr(buf_addr),
        .flash_buf_data(buf_data));

    fspc_cpu_model u_fspc_cpu_model (
        .clk(clk), .cpu_halt(cpu_halt), .spm_req(spm_req),
        .lpm_req(lpm_req), .z_ptr(z_ptr), .data_register_pair(dpair));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        apb(CSR_ADDR, 1'b1, d);
    endtask

    task automatic csr(input string n, input logic [7:0] e);
        apb(CSR_ADDR, 1'b0, 8'h0);
        chk(n, rd, {24'h0, e});
    endtask

    task automatic op(input logic s, input logic [15:0] z, d);
        u_fspc_cpu_model.issue(s, z, d);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic t_reset_bus;
        csr("csr_rst", CSR_RESET);
        chk("buf_rst", buf_data, 32'hffff);
        apb(12'h000, 1'b1, 8'h80);
        chk("err_wr", err, 32'h1);
        apb(12'h0e0, 1'b0, 8'h0);
        chk("err_rd", {err, rd[30:0]}, 32'h80000000);
        csr("csr_kept", 8'h00);
        $display("t_reset_bus done");
    endtask

    task automatic t_codes;
        logic [7:0] c[5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
        logic [7:0] b[4] = '{8'h07, 8'h1f, 8'h02, 8'h4c};
        foreach (c[i])
        begin
            wr(c[i]);
            wr(c[i]);
            csr("armed", c[i]);
            csr("expired", 8'h00);
        end
        foreach (b[i])
        begin
            wr(b[i]);
            csr("bad_code", 8'h00);
        end
        wr(8'h41);
        csr("busy_ro", 8'h01);
        repeat (4) @(posedge clk);
        $display("t_codes done");
    endtask

    task automatic t_fill;
        wr(8'h01);
        op(1'b1, 16'h0007, 16'h1234);
        buf_addr <= 5'd3;
        csr("filled", 8'h00);
        chk("buf_fill", buf_data, 32'h1234);
        wr(8'h21);
        op(1'b1, 16'h0009, 16'hbeef);
        buf_addr <= 5'd4;
        csr("sig_csr", 8'h00);
        chk("sig_store", buf_data, 32'hffff);
        boot <= 1'b0;
        wr(8'h01);
        op(1'b1, 16'h000b, 16'h5555);
        boot <= 1'b1;
        buf_addr <= 5'd5;
        repeat (5) @(posedge clk);
        chk("app_store", buf_data, 32'hffff);
        wr(8'h11);
        buf_addr <= 5'd3;
        @(posedge clk);
        chk("sect_clear", buf_data, 32'hffff);
        repeat (4) @(posedge clk);
        $display("t_fill done");
    endtask

    task automatic t_prog;
        logic [7:0] code;
        for (int i = 0; i < 2; i++)
        begin
            code = (i == 1) ? 8'h05 : 8'h03;
            wr(8'h01);
            op(1'b1, 16'h0003 + 16'(2 * i), 16'hcafe);
            wr(code);
            op(1'b1, 16'h1a40, 16'h0);
            @(negedge clk);
            chk("halt", cpu_halt, 32'h1);
            chk("op_kind", {flash_write, flash_erase}, i + 1);
            chk("page", flash_page, 32'h069);
            csr("csr_busy", code);
            while (cpu_halt === 1'b1)
                @(negedge clk);
            csr("csr_done", 8'h00);
            buf_addr <= 5'd1;
            @(posedge clk);
            chk("buf_after", buf_data, i ? 32'hffff : 32'hcafe);
        end
        $display("t_prog done");
    endtask

    task automatic t_lpm;
        logic [7:0] lx[4];
        lx = '{~FLO, ~LCK, ~FEX, ~FHI};
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h09);
            op(1'b0, 16'(k), 16'h0);
            @(negedge clk);
            chk("lock_hit", lpm_hit, 32'h1);
            chk("lock_data", lpm_data, lx[k]);
            wr(8'h21);
            op(1'b0, 16'(k), 16'h0);
            @(negedge clk);
            chk("sig_data", {lpm_hit, lpm_data}, {1'b1, SIG[8*k+:8]});
        end
        @(posedge clk);
        eep <= 1'b1;
        wr(8'h09);
        op(1'b0, 16'h0001, 16'h0);
        @(negedge clk);
        chk("lock_blocked", lpm_hit, 32'h0);
        $display("t_lpm done");
    endtask

    task automatic t_irq;
        @(posedge clk);
        eep <= 1'b0;
        gie <= 1'b1;
        wr(8'h80);
        @(negedge clk);
        chk("irq_on", ready_irq, 32'h1);
        @(posedge clk);
        eep <= 1'b1;
        @(negedge clk);
        chk("irq_eeprom", ready_irq, 32'h0);
        wr(8'h83);
        csr("csr_eeprom", 8'h80);
        eep <= 1'b0;
        wr(8'h81);
        @(negedge clk);
        chk("irq_armed", ready_irq, 32'h0);
        repeat (5) @(negedge clk);
        chk("irq_back", ready_irq, 32'h1);
        @(posedge clk);
        gie <= 1'b0;
        @(negedge clk);
        chk("irq_global", ready_irq, 32'h0);
        $display("t_irq done");
    endtask

    initial
    begin
        mismatches = 0;
        checks_done = 0;
        {rst_n, psel, penable, pwrite, gie, eep} = 6'h0;
        boot = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        buf_addr = 5'd0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_bus;
        t_codes;
        t_fill;
        t_prog;
        t_lpm;
        t_irq;
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim;
    end
endmodule // fspc_top_tb
